// File: core/upds_pkg.sv
// Package: map, field layout, reset values and bus carriers of the block
package upds_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Printed register indices; byte address is four times the index
	localparam logic [7:0] IDX_UP_BOOST = 8'hF6;
	localparam logic [7:0] IDX_DN_BOOST = 8'hF8;
	localparam logic [7:0] IDX_PIN_SWAP = 8'hFA;

	// Field positions
	localparam int UP_LVL_LSB   = 0;
	localparam int DN1_LVL_LSB  = 0;
	localparam int DN2_LVL_LSB  = 2;
	localparam int DN3_LVL_LSB  = 4;
	localparam int DN4_LVL_LSB  = 6;
	localparam int SWAP_UP_BIT  = 0;
	localparam int SWAP_DN1_BIT = 1;
	localparam int SWAP_W       = 5;

	// Values after reset: no boost, no swap
	localparam logic [1:0]        UP_BOOST_RST = 2'h0;
	localparam logic [7:0]        DN_BOOST_RST = 8'h00;
	localparam logic [SWAP_W-1:0] SWAP_RST     = 5'h00;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selector
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_UP   = 2'b01,
		SEL_DN   = 2'b10,
		SEL_SWAP = 2'b11
	} upds_sel_e;

	// Master to slave channel signals
	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} upds_axil_req_s;

	// Slave to master channel signals
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} upds_axil_rsp_s;

	// Whole state of the block
	typedef struct packed {
		logic [1:0]        up_boost;
		logic [7:0]        dn_boost;
		logic [SWAP_W-1:0] swap;
		logic              aw_got;
		logic [ADDR_W-1:0] awaddr;
		logic              w_got;
		logic [7:0]        wdata;
		logic              wstrb0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic              up_pos;
		logic              up_neg;
		logic [3:0]        dn_pos;
		logic [3:0]        dn_neg;
	} upds_state_s;

	localparam upds_state_s UPDS_ST_RST = '{
		up_boost: UP_BOOST_RST,
		dn_boost: DN_BOOST_RST,
		swap:     SWAP_RST,
		default:  '0
	};

endpackage

// File: core/upds_config.sv
// Drive boost and data pin swap configuration registers with AXI4-Lite slave
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps

// Function
// - Upstream boost level from bits 1:0
// - Port 4 boost from downstream bits 7:6
// - Port 3 boost from downstream bits 5:4
// - Port 2 boost from downstream bits 3:2
// - Port 1 boost from downstream bits 1:0
// - Swap bit one exchanges D+ and D-
// - Swap bits 1..4 steer downstream ports 1..4
// - Swap bit 0 steers upstream port
module upds_config
	import upds_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           nrst,
	input  wire upds_axil_req_s axi_req,
	output upds_axil_rsp_s      axi_rsp,
	output logic [1:0]          upstream_boost_level,
	output logic [1:0]          down1_boost_level,
	output logic [1:0]          down2_boost_level,
	output logic [1:0]          down3_boost_level,
	output logic [1:0]          down4_boost_level,
	output logic [SWAP_W-1:0]   pin_swap_bits,
	input  wire logic           upstream_dp_tx,
	input  wire logic           upstream_dm_tx,
	input  wire logic [3:0]     downstream_dp_tx,
	input  wire logic [3:0]     downstream_dm_tx,
	output logic                upstream_pos_pin,
	output logic                upstream_neg_pin,
	output logic [3:0]          downstream_pos_pin,
	output logic [3:0]          downstream_neg_pin
);

	// Word address decode, shared by the read and write paths
	function automatic upds_sel_e reg_sel(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] w;
		w = a[ADDR_W-1:2];
		if (w == {2'h0, IDX_UP_BOOST})
			reg_sel = SEL_UP;
		else if (w == {2'h0, IDX_DN_BOOST})
			reg_sel = SEL_DN;
		else if (w == {2'h0, IDX_PIN_SWAP})
			reg_sel = SEL_SWAP;
		else
			reg_sel = SEL_NONE;
	endfunction

	upds_state_s st_ff;
	upds_state_s nxt_st;
	logic        aw_fire;
	logic        w_fire;
	logic        ar_fire;
	logic        wr_fire;
	upds_sel_e   wr_sel;
	upds_sel_e   rd_sel;

	// Handshakes; a channel is held off while its answer is pending
	assign axi_rsp.awready = !st_ff.aw_got && !st_ff.bvalid;
	assign axi_rsp.wready  = !st_ff.w_got && !st_ff.bvalid;
	assign axi_rsp.arready = !st_ff.rvalid;
	assign axi_rsp.bvalid  = st_ff.bvalid;
	assign axi_rsp.bresp   = st_ff.bresp;
	assign axi_rsp.rvalid  = st_ff.rvalid;
	assign axi_rsp.rdata   = st_ff.rdata;
	assign axi_rsp.rresp   = st_ff.rresp;

	assign aw_fire = axi_req.awvalid && axi_rsp.awready;
	assign w_fire  = axi_req.wvalid && axi_rsp.wready;
	assign ar_fire = axi_req.arvalid && axi_rsp.arready;
	assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign wr_sel  = reg_sel(st_ff.awaddr);
	assign rd_sel  = reg_sel(axi_req.araddr);

	// Static controls and steered pins straight from the register flops
	assign upstream_boost_level = st_ff.up_boost;
	assign down4_boost_level = st_ff.dn_boost[DN4_LVL_LSB +: 2];
	assign down3_boost_level = st_ff.dn_boost[DN3_LVL_LSB +: 2];
	assign down2_boost_level = st_ff.dn_boost[DN2_LVL_LSB +: 2];
	assign down1_boost_level = st_ff.dn_boost[DN1_LVL_LSB +: 2];
	assign pin_swap_bits      = st_ff.swap;
	assign upstream_pos_pin   = st_ff.up_pos;
	assign upstream_neg_pin   = st_ff.up_neg;
	assign downstream_pos_pin = st_ff.dn_pos;
	assign downstream_neg_pin = st_ff.dn_neg;

	// Next state: bus slave, register writes, read data, pin steering
	always_comb begin
		nxt_st = st_ff;
		// Address and data may arrive in either order
		if (aw_fire) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = axi_req.awaddr;
		end
		if (w_fire) begin
			nxt_st.w_got  = 1'b1;
			nxt_st.wdata  = axi_req.wdata[7:0];
			nxt_st.wstrb0 = axi_req.wstrb[0];
		end
		// Only the low byte lane holds register bits
		if (wr_fire) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (st_ff.wstrb0) begin
				unique case (wr_sel)
					SEL_UP: begin
						// Upper bits dropped on write
						nxt_st.up_boost = st_ff.wdata[UP_LVL_LSB +: 2];
					end
					SEL_DN: begin
						nxt_st.dn_boost = st_ff.wdata;
					end
					SEL_SWAP: begin
						nxt_st.swap = st_ff.wdata[SWAP_W-1:0];
					end
					SEL_NONE: begin
						nxt_st.bresp = RESP_SLVERR;
					end
				endcase
			end
		end else if (st_ff.bvalid && axi_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Read answer; reserved bits return zero
		if (ar_fire) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = RESP_OKAY;
			unique case (rd_sel)
				SEL_UP:   nxt_st.rdata = {30'h0, st_ff.up_boost};
				SEL_DN:   nxt_st.rdata = {24'h0, st_ff.dn_boost};
				SEL_SWAP: nxt_st.rdata = {27'h0, st_ff.swap};
				SEL_NONE: begin
					nxt_st.rdata = 32'h0;
					nxt_st.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st_ff.rvalid && axi_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end
		// Registered pin steering keeps the pins glitch free on a swap
		nxt_st.up_pos = st_ff.swap[SWAP_UP_BIT] ? upstream_dm_tx
		                                        : upstream_dp_tx;
		nxt_st.up_neg = st_ff.swap[SWAP_UP_BIT] ? upstream_dp_tx
		                                        : upstream_dm_tx;
		for (int i = 0; i < 4; i++) begin
			nxt_st.dn_pos[i] = st_ff.swap[SWAP_DN1_BIT+i] ? downstream_dm_tx[i]
			                                             : downstream_dp_tx[i];
			nxt_st.dn_neg[i] = st_ff.swap[SWAP_DN1_BIT+i] ? downstream_dp_tx[i]
			                                             : downstream_dm_tx[i];
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clk) begin
		if (!nrst)
			st_ff <= UPDS_ST_RST;
		else
			st_ff <= nxt_st;
	end

	// Write of a given register with the low lane enabled
	sequence s_wr_up;
		wr_fire && wr_sel == SEL_UP && st_ff.wstrb0;
	endsequence

	sequence s_wr_dn;
		wr_fire && wr_sel == SEL_DN && st_ff.wstrb0;
	endsequence

	sequence s_wr_swap;
		wr_fire && wr_sel == SEL_SWAP && st_ff.wstrb0;
	endsequence

	property p_up_level;
		@(posedge clk) disable iff (!nrst)
		s_wr_up |=> upstream_boost_level == $past(st_ff.wdata[1:0]);
	endproperty
	a_up_level: assert property (p_up_level)
		else $error("upstream boost level not taken from bits 1:0");

	property p_dn4_level;
		@(posedge clk) disable iff (!nrst)
		s_wr_dn |=> down4_boost_level == $past(st_ff.wdata[7:6]);
	endproperty
	a_dn4_level: assert property (p_dn4_level)
		else $error("port 4 boost not taken from bits 7:6");

	property p_dn3_level;
		@(posedge clk) disable iff (!nrst)
		s_wr_dn |=> down3_boost_level == $past(st_ff.wdata[5:4]);
	endproperty
	a_dn3_level: assert property (p_dn3_level)
		else $error("port 3 boost not taken from bits 5:4");

	property p_dn2_level;
		@(posedge clk) disable iff (!nrst)
		s_wr_dn |=> down2_boost_level == $past(st_ff.wdata[3:2]);
	endproperty
	a_dn2_level: assert property (p_dn2_level)
		else $error("port 2 boost not taken from bits 3:2");

	property p_dn1_level;
		@(posedge clk) disable iff (!nrst)
		s_wr_dn |=> down1_boost_level == $past(st_ff.wdata[1:0]);
	endproperty
	a_dn1_level: assert property (p_dn1_level)
		else $error("port 1 boost not taken from bits 1:0");

	// Only from an edge that saw reset high: the edge after release still
	// shows reset pin values, whatever the transmit levels were
	property p_dn_swap;
		@(posedge clk) disable iff (!nrst)
		nrst |=> downstream_pos_pin[0] == ($past(pin_swap_bits[1]) ?
			$past(downstream_dm_tx[0]) : $past(downstream_dp_tx[0]))
			&& downstream_neg_pin[3] == ($past(pin_swap_bits[4]) ?
			$past(downstream_dp_tx[3]) : $past(downstream_dm_tx[3]));
	endproperty
	a_dn_swap: assert property (p_dn_swap)
		else $error("downstream pin roles not steered by swap bits");

	property p_up_swap;
		@(posedge clk) disable iff (!nrst)
		s_wr_swap ##1 (pin_swap_bits[0] == 1'b1) ##1 1'b1 |->
			upstream_pos_pin == $past(upstream_dm_tx)
			&& upstream_neg_pin == $past(upstream_dp_tx);
	endproperty
	a_up_swap: assert property (p_up_swap)
		else $error("upstream pins not exchanged with swap bit 0 set");

	property p_rsvd_zero;
		@(posedge clk) disable iff (!nrst)
		ar_fire && (rd_sel == SEL_UP || rd_sel == SEL_SWAP) |=>
			axi_rsp.rvalid && axi_rsp.rdata[31:5] == 27'h0
			&& ($past(rd_sel) != SEL_UP || axi_rsp.rdata[4:2] == 3'h0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits read nonzero");

	property p_bresp_hold;
		@(posedge clk) disable iff (!nrst)
		axi_rsp.bvalid && !axi_req.bready |=>
			axi_rsp.bvalid && $stable(axi_rsp.bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write answer dropped before taken");

	property p_wr_answer;
		@(posedge clk) disable iff (!nrst)
		wr_fire |=> axi_rsp.bvalid && !axi_rsp.awready && !axi_rsp.wready;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer missing one cycle after both halves");

	// Write with lane 0 off, and the edge at which the answer is taken
	sequence s_wr_nolane;
		wr_fire && !st_ff.wstrb0;
	endsequence

	sequence s_b_taken;
		axi_rsp.bvalid && axi_req.bready;
	endsequence

	property p_no_lane;
		@(posedge clk) disable iff (!nrst)
		s_wr_nolane |=> $stable(upstream_boost_level)
			&& $stable(st_ff.dn_boost) && $stable(pin_swap_bits);
	endproperty
	a_no_lane: assert property (p_no_lane)
		else $error("register changed by a write with lane 0 off");

	property p_wr_release;
		@(posedge clk) disable iff (!nrst)
		s_b_taken |=> !axi_rsp.bvalid
			&& axi_rsp.awready && axi_rsp.wready;
	endproperty
	a_wr_release: assert property (p_wr_release)
		else $error("write channels not reopened after answer taken");

	property p_rd_answer;
		@(posedge clk) disable iff (!nrst)
		ar_fire |=> axi_rsp.rvalid && !axi_rsp.arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer missing one cycle after address");

	// A stalled read answer must not change under the master
	property p_rdata_hold;
		@(posedge clk) disable iff (!nrst)
		axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
			&& $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read answer changed before taken");

	property p_swap_store;
		@(posedge clk) disable iff (!nrst)
		s_wr_swap |=>
			pin_swap_bits == $past(st_ff.wdata[SWAP_W-1:0]);
	endproperty
	a_swap_store: assert property (p_swap_store)
		else $error("swap bits not taken from bits 4:0");

	// Every downstream port, both roles, one edge after its inputs
	property p_dn_steer;
		@(posedge clk) disable iff (!nrst)
		nrst |=> downstream_pos_pin == (($past(downstream_dm_tx)
			& $past(pin_swap_bits[4:1])) | ($past(downstream_dp_tx)
			& ~$past(pin_swap_bits[4:1])))
			&& downstream_neg_pin == (($past(downstream_dp_tx)
			& $past(pin_swap_bits[4:1])) | ($past(downstream_dm_tx)
			& ~$past(pin_swap_bits[4:1])));
	endproperty
	a_dn_steer: assert property (p_dn_steer)
		else $error("downstream pin roles not steered per port");

	// Clear swap bit keeps the upstream roles straight
	property p_up_straight;
		@(posedge clk) disable iff (!nrst)
		nrst && !pin_swap_bits[SWAP_UP_BIT] |=>
			upstream_pos_pin == $past(upstream_dp_tx)
			&& upstream_neg_pin == $past(upstream_dm_tx);
	endproperty
	a_up_straight: assert property (p_up_straight)
		else $error("upstream pins swapped with swap bit 0 clear");

endmodule // upds_config

// File: sim/upds_config_tb_top.sv
// Self-checking bench for the boost and pin swap register block
`timescale 1ns/100ps
module upds_config_tb_top
	import upds_pkg::*;
;
	logic              clk;
	logic              nrst;
	upds_axil_req_s    req;
	upds_axil_rsp_s    rsp;
	logic [1:0]        up_lvl, d1, d2, d3, d4;
	logic [SWAP_W-1:0] swap;
	logic              up_dp, up_dm, up_p, up_n;
	logic [3:0]        dn_dp, dn_dm, dn_p, dn_n;
	int                miscompares;
	int                comparisons;
	logic [1:0]        exp_b[$];
	logic [33:0]       exp_r[$];
	logic [7:0]        m_up, m_dn;
	logic [4:0]        m_sw;
	logic [11:0]       addr_tab[4];

	upds_config DUT (.clk(clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
		.upstream_boost_level(up_lvl), .down1_boost_level(d1),
		.down2_boost_level(d2), .down3_boost_level(d3),
		.down4_boost_level(d4), .pin_swap_bits(swap),
		.upstream_dp_tx(up_dp), .upstream_dm_tx(up_dm),
		.downstream_dp_tx(dn_dp), .downstream_dm_tx(dn_dm),
		.upstream_pos_pin(up_p), .upstream_neg_pin(up_n),
		.downstream_pos_pin(dn_p), .downstream_neg_pin(dn_n));

	// Free running 200 MHz clock
	always #2.5 clk = ~clk;

	task automatic check(input logic [33:0] seen, exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Bus answers are matched in order against what the driver noted
	always @(posedge clk) begin
		if (rsp.bvalid && req.bready)
			check(34'(rsp.bresp), 34'(exp_b.pop_front()), "bresp");
		if (rsp.rvalid && req.rready)
			check({rsp.rresp, rsp.rdata}, exp_r.pop_front(), "read");
	end

	// Write master: releases each channel once taken, idles one cycle after;
	// a random lag on bready makes the answer stall against the master
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] eb);
		int unsigned lag;
		lag = $urandom_range(4);
		exp_b.push_back(eb);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= s;
		req.wvalid <= 1'b1;
		req.bready <= (lag == 0);
		do begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (lag == 1) req.bready <= 1'b1;
			if (lag > 0) lag--;
		end while (!(rsp.bvalid && req.bready));
		req.bready <= 1'b0;
		@(posedge clk);
	endtask

	// Read master with a random lag of up to 3 cycles on rready, one less than on bready
	task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
		int unsigned lag;
		lag = $urandom_range(3);
		exp_r.push_back(e);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= (lag == 0);
		do begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (lag == 1) req.rready <= 1'b1;
			if (lag > 0) lag--;
		end while (!(rsp.rvalid && req.rready));
		req.rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk_out();
		check(34'(up_lvl), 34'(m_up[1:0]), "up level");
		check(34'(d4), 34'(m_dn[7:6]), "port4 level");
		check(34'(d3), 34'(m_dn[5:4]), "port3 level");
		check(34'(d2), 34'(m_dn[3:2]), "port2 level");
		check(34'(d1), 34'(m_dn[1:0]), "port1 level");
		check(34'(swap), 34'(m_sw), "swap bits");
	endtask

	// Pins lag the transmit levels by one cycle, so sample two edges later
	task automatic chk_pins();
		logic [4:0] dp, dm;
		dp = {dn_dp, up_dp};
		dm = {dn_dm, up_dm};
		check(34'({dn_p, up_p}), 34'((dm & m_sw) | (dp & ~m_sw)), "pos");
		check(34'({dn_n, up_n}), 34'((dp & m_sw) | (dm & ~m_sw)), "neg");
	endtask

	// Index 3 of the table is an unmapped word, answered with an error
	task automatic wr_reg(input int k, input logic [31:0] d, input logic [3:0] s);
		axi_wr(addr_tab[k], d, s, (k == 3) ? RESP_SLVERR : RESP_OKAY);
		if (s[0]) begin
			case (k)
				0: m_up = {6'h00, d[1:0]};
				1: m_dn = d[7:0];
				2: m_sw = d[4:0];
				default: ;
			endcase
		end
		chk_out();
	endtask

	task automatic rd_reg(input int k);
		logic [31:0] e;
		e = (k == 0) ? {24'h0, m_up} : (k == 1) ? {24'h0, m_dn} :
			(k == 2) ? {27'h0, m_sw} : 32'h0;
		axi_rd(addr_tab[k], {(k == 3) ? RESP_SLVERR : RESP_OKAY, e});
	endtask

	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		logic [31:0] d;
		clk = 1'b0;
		nrst = 1'b0;
		req = '0;
		{up_dp, up_dm, dn_dp, dn_dm} = '0;
		{m_up, m_dn, m_sw} = '0;
		addr_tab = '{{2'h0, IDX_UP_BOOST, 2'h0}, {2'h0, IDX_DN_BOOST, 2'h0},
			{2'h0, IDX_PIN_SWAP, 2'h0}, 12'h3E4};
		void'($urandom(6328));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 4; k++) rd_reg(k);
		chk_out();
		$display("test reset values done");
		// Every level code in every field, random upper bits for reserved
		for (int c = 0; c < 12; c++) begin
			for (int k = 0; k < 4; k++) begin
				d = $urandom;
				if (c < 4) d[7:0] = {4{2'(c)}};
				wr_reg(k, d, 4'hF);
				rd_reg(k);
			end
		end
		$display("test levels and reserved done");
		// Lane 0 strobe off leaves the word untouched
		for (int k = 0; k < 4; k++) begin
			wr_reg(k, $urandom, 4'hE);
			rd_reg(k);
		end
		$display("test strobe off done");
		for (int v = 0; v < 32; v++) begin
			wr_reg(2, ($urandom & 32'hFFFFFFE0) | 32'(v), 4'hF);
			repeat (3) begin
				{up_dp, up_dm, dn_dp, dn_dm} <= 10'($urandom);
				@(posedge clk);
				@(posedge clk);
				chk_pins();
			end
		end
		$display("test pin steering done");
		for (int k = 0; k < 3; k++) wr_reg(k, 32'h0, 4'hF);
		wr_reg(1, $urandom, 4'hF);
		wr_reg(2, $urandom, 4'hF);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		{m_up, m_dn, m_sw} = '0;
		@(posedge clk);
		for (int k = 0; k < 4; k++) rd_reg(k);
		chk_out();
		$display("test second reset done");
		report_and_stop();
	end

endmodule // upds_config_tb_top
